// ==== verilog/pbc_cfg.svh ====
/*
  Constants of the basic control/status register pair: register numbers,
  field positions, reset values, write mask and management frame field lengths less one.
  Assumes inclusion by bare name from the design file.
*/
`ifndef PBC_CFG_SVH
`define PBC_CFG_SVH

`define PBC_REG_CONTROL      5'h00
`define PBC_REG_STATUS       5'h01

`define PBC_BIT_SOFT_RESET   15
`define PBC_BIT_LOOPBACK     14
`define PBC_BIT_SPEED        13
`define PBC_BIT_AN_ENABLE    12
`define PBC_BIT_POWER_DOWN   11
`define PBC_BIT_ISOLATE      10
`define PBC_BIT_AN_RESTART   9
`define PBC_BIT_DUPLEX       8
`define PBC_BIT_COL_TEST     7
`define PBC_BIT_TX_DISABLE   0

`define PBC_CTRL_RESET       16'h0000
`define PBC_CTRL_WR_MASK     16'h7D81
`define PBC_STATUS_VALUE     16'h7849
`define PBC_UNMAPPED_VALUE   16'h0000

`define PBC_OP_WRITE         2'h1
`define PBC_OP_READ          2'h2
`define PBC_OP_BITS          4'h1
`define PBC_ADDR_BITS        4'h9
`define PBC_TURN_BITS        4'h1
`define PBC_DATA_BITS        4'hF

`endif

// ==== verilog/pbc_pkg.sv ====
/*
  Types of the basic control/status register block.
  Assumes nothing of its surroundings.
*/
package pbc_pkg;

  typedef enum logic [5:0] {
    PBC_IDLE   = 6'h01,
    PBC_START  = 6'h02,
    PBC_OPCODE = 6'h04,
    PBC_ADDR   = 6'h08,
    PBC_TURN   = 6'h10,
    PBC_DATA   = 6'h20
  } pbc_state_e;

endpackage : pbc_pkg

// ==== verilog/pbc_regs.sv ====
/*
  Basic control and basic status registers of a 10/100 PHY, reached over
  the MDC/MDIO management pins, with the control fields driven out.
  Assumes MDC and MDIO are synchronous to I_CLOCK and MDC is well below
  half its rate; straps are steady around reset release.
*/
`timescale 1ns/10ps
`default_nettype none
`include "pbc_cfg.svh"

module pbc_regs
  import pbc_pkg::*;
(
  input  wire logic       I_CLOCK,
  input  wire logic       I_RST_N,
  input  wire logic       I_MDC,
  input  wire logic       I_MDIO_IN,
  output var  logic       O_MDIO_OUT,
  output var  logic       O_MDIO_OE_N,
  input  wire logic [4:0] I_PHY_ADDR,
  input  wire logic       I_SPEED_STRAP,
  input  wire logic       I_AUTONEG_DEFAULT_STRAP,
  input  wire logic       I_ISOLATE_STRAP,
  input  wire logic       I_DUPLEX_STRAP,
  input  wire logic       I_AN_SPEED_100,
  input  wire logic       I_AN_FULL_DUPLEX,
  output var  logic       O_SOFT_RESET,
  output var  logic       O_AN_RESTART,
  output var  logic       O_AN_ENABLE,
  output var  logic       O_SPEED_100,
  output var  logic       O_FULL_DUPLEX,
  output var  logic       O_LOOPBACK,
  output var  logic       O_POWER_DOWN,
  output var  logic       O_ISOLATE,
  output var  logic       O_TX_DISABLE,
  output var  logic       O_COL_TEST
);

  // control word built from strap levels
  function automatic logic [15:0] strap_word(input logic spd, input logic an,
                                             input logic iso, input logic dpx);
    logic [15:0] w;
    w = `PBC_CTRL_RESET;
    w[`PBC_BIT_SPEED]     = spd;
    w[`PBC_BIT_AN_ENABLE] = an;
    w[`PBC_BIT_ISOLATE]   = iso;
    w[`PBC_BIT_DUPLEX]    = dpx;
    return w;
  endfunction : strap_word

  logic [15:0] ctrl_r;
  logic [15:0] ctrl_nxt;
  logic [15:0] strap_ctrl_r;
  logic        strap_done_r;
  logic        soft_reset_r;
  logic        an_restart_r;
  logic        mdc_d_r;
  logic        last_bit_r;
  pbc_state_e  state_r;
  pbc_state_e  state_nxt;
  logic [3:0]  cnt_r;
  logic [3:0]  cnt_nxt;
  logic [15:0] shift_r;
  logic [15:0] shift_nxt;
  logic [4:0]  reg_r;
  logic [4:0]  reg_nxt;
  logic [15:0] rd_shift_r;
  logic [15:0] rd_shift_nxt;
  logic        is_read_r;
  logic        is_read_nxt;
  logic        mdio_out_r;
  logic        mdio_out_nxt;
  logic        mdio_drive_r;
  logic        mdio_drive_nxt;
  logic        wr_commit;

  wire         mdc_rise   = I_MDC & ~mdc_d_r;
  wire [15:0]  wr_word    = {shift_r[14:0], I_MDIO_IN};
  wire [4:0]   frame_phy  = shift_r[8:4];
  wire [4:0]   frame_reg  = {shift_r[3:0], I_MDIO_IN};
  wire [1:0]   frame_op   = shift_r[10:9];
  wire         addr_hit   = (frame_phy == I_PHY_ADDR);
  // register number held apart, since write data shifts through shift_r
  wire         sel_ctrl   = (reg_r == `PBC_REG_CONTROL);
  wire         sel_status = (reg_r == `PBC_REG_STATUS);
  wire [15:0]  ctrl_view  = ctrl_r & `PBC_CTRL_WR_MASK;
  wire [15:0]  rd_word    = sel_ctrl   ? ctrl_view :
                            sel_status ? `PBC_STATUS_VALUE :
                                         `PBC_UNMAPPED_VALUE;
  wire         ctrl_wr    = wr_commit & sel_ctrl;
  wire         wr_reset   = ctrl_wr & wr_word[`PBC_BIT_SOFT_RESET];
  wire         wr_restart = ctrl_wr & wr_word[`PBC_BIT_AN_RESTART];
  wire         an_on      = ctrl_r[`PBC_BIT_AN_ENABLE];

  // management frame decoder, stepped once per MDC rising edge
  always_comb begin
    state_nxt      = state_r;
    cnt_nxt        = cnt_r;
    shift_nxt      = shift_r;
    reg_nxt        = reg_r;
    rd_shift_nxt   = rd_shift_r;
    is_read_nxt    = is_read_r;
    mdio_out_nxt   = mdio_out_r;
    mdio_drive_nxt = mdio_drive_r;
    wr_commit      = 1'b0;
    if (mdc_rise) begin
      case (state_r)
        PBC_IDLE: begin
          if (!I_MDIO_IN && last_bit_r) begin
            state_nxt = PBC_START;
          end
        end
        PBC_START: begin
          state_nxt = I_MDIO_IN ? PBC_OPCODE : PBC_IDLE;
          cnt_nxt   = 4'h0;
        end
        PBC_OPCODE: begin
          shift_nxt = {shift_r[14:0], I_MDIO_IN};
          cnt_nxt   = cnt_r + 4'h1;
          if (cnt_r == `PBC_OP_BITS) begin
            state_nxt = PBC_ADDR;
            cnt_nxt   = 4'h0;
          end
        end
        PBC_ADDR: begin
          shift_nxt = {shift_r[14:0], I_MDIO_IN};
          cnt_nxt   = cnt_r + 4'h1;
          if (cnt_r == `PBC_ADDR_BITS) begin
            cnt_nxt     = 4'h0;
            is_read_nxt = (frame_op == `PBC_OP_READ);
            if (addr_hit && (frame_op == `PBC_OP_READ || frame_op == `PBC_OP_WRITE)) begin
              state_nxt = PBC_TURN;
              shift_nxt = {11'h000, frame_reg};
              reg_nxt   = frame_reg;
            end else begin
              state_nxt = PBC_IDLE;
            end
          end
        end
        PBC_TURN: begin
          cnt_nxt = cnt_r + 4'h1;
          if (is_read_r && cnt_r == 4'h0) begin
            mdio_drive_nxt = 1'b1;
            mdio_out_nxt   = 1'b0;
          end
          if (cnt_r == `PBC_TURN_BITS) begin
            state_nxt = PBC_DATA;
            cnt_nxt   = 4'h0;
            if (is_read_r) begin
              mdio_out_nxt = rd_word[15];
              rd_shift_nxt = {rd_word[14:0], 1'b0};
            end
          end
        end
        PBC_DATA: begin
          cnt_nxt = cnt_r + 4'h1;
          if (is_read_r) begin
            mdio_out_nxt = rd_shift_r[15];
            rd_shift_nxt = {rd_shift_r[14:0], 1'b0};
          end else begin
            shift_nxt = {shift_r[14:0], I_MDIO_IN};
          end
          if (cnt_r == `PBC_DATA_BITS) begin
            state_nxt      = PBC_IDLE;
            mdio_drive_nxt = 1'b0;
            mdio_out_nxt   = 1'b0;
            wr_commit      = ~is_read_r;
          end
        end
        default: begin
          state_nxt      = PBC_IDLE;
          mdio_drive_nxt = 1'b0;
        end
      endcase
    end
  end

  // control register next value
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (!strap_done_r) begin
      ctrl_nxt = strap_word(I_SPEED_STRAP, I_AUTONEG_DEFAULT_STRAP, I_ISOLATE_STRAP, I_DUPLEX_STRAP);
    end else if (wr_reset) begin
      ctrl_nxt = strap_ctrl_r;
    end else if (ctrl_wr) begin
      ctrl_nxt = wr_word & `PBC_CTRL_WR_MASK;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_r      <= PBC_IDLE;
      cnt_r        <= 4'h0;
      shift_r      <= 16'h0000;
      reg_r        <= 5'h00;
      rd_shift_r   <= 16'h0000;
      is_read_r    <= 1'b0;
      mdio_out_r   <= 1'b0;
      mdio_drive_r <= 1'b0;
      mdc_d_r      <= 1'b0;
      last_bit_r   <= 1'b0;
    end else begin
      state_r      <= state_nxt;
      cnt_r        <= cnt_nxt;
      shift_r      <= shift_nxt;
      reg_r        <= reg_nxt;
      rd_shift_r   <= rd_shift_nxt;
      is_read_r    <= is_read_nxt;
      mdio_out_r   <= mdio_out_nxt;
      mdio_drive_r <= mdio_drive_nxt;
      mdc_d_r      <= I_MDC;
      last_bit_r   <= mdc_rise ? I_MDIO_IN : last_bit_r;
    end
  end

  // straps caught on the first edge after reset release
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      strap_done_r <= 1'b0;
      strap_ctrl_r <= `PBC_CTRL_RESET;
    end else if (!strap_done_r) begin
      strap_done_r <= 1'b1;
      strap_ctrl_r <= ctrl_nxt;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ctrl_r       <= `PBC_CTRL_RESET;
      soft_reset_r <= 1'b0;
      an_restart_r <= 1'b0;
    end else begin
      ctrl_r       <= ctrl_nxt;
      soft_reset_r <= wr_reset;
      an_restart_r <= wr_restart & ~wr_reset;
    end
  end

  assign O_MDIO_OUT    = mdio_out_r;
  assign O_MDIO_OE_N   = ~mdio_drive_r;
  assign O_SOFT_RESET  = soft_reset_r;
  assign O_AN_RESTART  = an_restart_r;
  assign O_AN_ENABLE   = an_on;
  // negotiated result wins while negotiation is on
  assign O_SPEED_100   = an_on ? I_AN_SPEED_100 : ctrl_r[`PBC_BIT_SPEED];
  assign O_FULL_DUPLEX = an_on ? I_AN_FULL_DUPLEX : ctrl_r[`PBC_BIT_DUPLEX];
  assign O_LOOPBACK    = ctrl_r[`PBC_BIT_LOOPBACK];
  assign O_POWER_DOWN  = ctrl_r[`PBC_BIT_POWER_DOWN];
  assign O_ISOLATE     = ctrl_r[`PBC_BIT_ISOLATE];
  // isolation also silences the twisted-pair transmitter
  assign O_TX_DISABLE  = ctrl_r[`PBC_BIT_TX_DISABLE] | ctrl_r[`PBC_BIT_ISOLATE];
  assign O_COL_TEST    = ctrl_r[`PBC_BIT_COL_TEST];

endmodule : pbc_regs
`default_nettype wire

// ==== dv/pbc_regs_assertions.sv ====
/*
  Port checker for the basic control/status register block.
  Assumes binding onto pbc_regs; sees its ports only.
*/
`timescale 1ns/10ps
`default_nettype none
module pbc_regs_assertions (
  input wire logic I_CLOCK,
  input wire logic I_RST_N,
  input wire logic I_AN_SPEED_100,
  input wire logic I_AN_FULL_DUPLEX,
  input wire logic O_MDIO_OUT,
  input wire logic O_MDIO_OE_N,
  input wire logic O_SOFT_RESET,
  input wire logic O_AN_RESTART,
  input wire logic O_AN_ENABLE,
  input wire logic O_SPEED_100,
  input wire logic O_FULL_DUPLEX,
  input wire logic O_LOOPBACK,
  input wire logic O_POWER_DOWN,
  input wire logic O_ISOLATE,
  input wire logic O_TX_DISABLE,
  input wire logic O_COL_TEST
);
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_N);
  AST_ISO_TXOFF: assert property (O_ISOLATE |-> O_TX_DISABLE) else $error("isolate without tx off");
  AST_AN_SPEED: assert property (O_AN_ENABLE |-> O_SPEED_100 == I_AN_SPEED_100) else $error("speed");
  AST_AN_DUPLEX: assert property (O_AN_ENABLE |-> O_FULL_DUPLEX == I_AN_FULL_DUPLEX) else $error("duplex");
  AST_SRST_PULSE: assert property (O_SOFT_RESET |=> !O_SOFT_RESET) else $error("soft reset stuck");
  AST_RESTART_PULSE: assert property (O_AN_RESTART |=> !O_AN_RESTART) else $error("restart stuck");
  AST_SRST_CLEAR: assert property (O_SOFT_RESET |=> !O_LOOPBACK && !O_POWER_DOWN && !O_COL_TEST)
    else $error("soft reset kept bits");
  AST_READ_STABLE: assert property (!O_MDIO_OE_N |=> $stable({O_LOOPBACK, O_POWER_DOWN, O_COL_TEST, O_AN_ENABLE}))
    else $error("control moved in read");
  AST_READ_TURN: assert property ($fell(O_MDIO_OE_N) |-> !O_MDIO_OUT ##1 !O_MDIO_OE_N [*8])
    else $error("read turnaround");
  C_SRST: cover property (O_SOFT_RESET);
  C_RESTART: cover property (O_AN_RESTART);
  C_READ: cover property ($fell(O_MDIO_OE_N));
endmodule : pbc_regs_assertions
`default_nettype wire

// ==== dv/pbc_mdio_mgr.sv ====
/*
  Station manager model: sends management frames, gathers read data.
  Assumes the line is pulled up when nobody drives it.
*/
`timescale 1ns/10ps
`default_nettype none
module pbc_mdio_mgr (
  input  wire logic        i_clk,
  input  wire logic        i_dev_out,
  input  wire logic        i_dev_oe_n,
  output var  logic        o_mdc,
  output var  logic        o_mdio,
  output var  logic        o_done,
  output var  logic [15:0] o_rdata
);
  logic        m_en;
  logic        m_dat;
  logic [15:0] sh;
  assign o_mdio = !i_dev_oe_n ? i_dev_out : (m_en ? m_dat : 1'b1);
  initial begin
    o_mdc = 1'b0;
    m_en = 1'b0;
    m_dat = 1'b1;
    o_done = 1'b0;
    o_rdata = 16'h0000;
  end
  // one preamble one, start, op, address, turnaround, data; clock still between frames
  task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] wd);
    logic [32:0] w;
    w = {3'b101, op, pa, ra, 2'b10, wd};
    for (int i = 32; i >= 0; i--) begin
      @(negedge i_clk);
      o_mdc = 1'b0;
      m_en = (op == 2'h1) || (i > 17);
      m_dat = w[i];
      repeat (2) @(negedge i_clk);
      sh = {sh[14:0], o_mdio};
      o_mdc = 1'b1;
      @(negedge i_clk);
    end
    m_en = 1'b0;
    o_rdata = sh;
    o_done = (op == 2'h2);
    @(negedge i_clk);
    o_done = 1'b0;
  endtask : frame
endmodule : pbc_mdio_mgr
`default_nettype wire

// ==== dv/pbc_regs_tb.sv ====
/*
  Self-checking bench of the basic control/status registers.
  Assumes the manager model and the port checker beside it.
*/
`timescale 1ns/10ps
`default_nettype none
module pbc_regs_tb;
  logic I_CLOCK, I_RST_N, I_MDC, I_MDIO_IN, O_MDIO_OUT, O_MDIO_OE_N;
  logic I_SPEED_STRAP, I_AUTONEG_DEFAULT_STRAP, I_ISOLATE_STRAP, I_DUPLEX_STRAP;
  logic I_AN_SPEED_100, I_AN_FULL_DUPLEX, O_SOFT_RESET, O_AN_RESTART, O_AN_ENABLE;
  logic O_SPEED_100, O_FULL_DUPLEX, O_LOOPBACK, O_POWER_DOWN, O_ISOLATE, O_TX_DISABLE, O_COL_TEST;
  logic [4:0]  I_PHY_ADDR;
  logic        done;
  logic [15:0] rdata;
  logic [15:0] strap_w;
  logic [15:0] v;
  logic [15:0] exq[$];
  logic [15:0] an_cnt;
  logic [15:0] srst_cnt;
  logic [15:0] an_exp;
  int          fails;
  int          tests_run;
  always #5 I_CLOCK = ~I_CLOCK;
  pbc_regs dut_u (.*);
  pbc_mdio_mgr mgr_u (.i_clk(I_CLOCK), .i_dev_out(O_MDIO_OUT), .i_dev_oe_n(O_MDIO_OE_N), .o_mdc(I_MDC),
    .o_mdio(I_MDIO_IN), .o_done(done), .o_rdata(rdata));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic rd(input logic [4:0] ra, input logic [15:0] exp);
    exq.push_back(exp);
    mgr_u.frame(2'h2, I_PHY_ADDR, ra, 16'h0000);
  endtask : rd
  task automatic outs(input logic [15:0] c);
    check({8'h00, O_SPEED_100, O_FULL_DUPLEX, O_AN_ENABLE, O_LOOPBACK, O_POWER_DOWN, O_ISOLATE, O_TX_DISABLE, O_COL_TEST},
      {8'h00, c[12] ? I_AN_SPEED_100 : c[13], c[12] ? I_AN_FULL_DUPLEX : c[8], c[12], c[14], c[11], c[10],
       c[10] | c[0], c[7]});
  endtask : outs
  task automatic tally_and_finish;
    $display("tests_run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  always @(posedge done) check(rdata, exq.pop_front());
  // pulse counters for the self-clearing command bits
  always @(posedge I_CLOCK) begin
    if (O_AN_RESTART) an_cnt <= an_cnt + 16'h0001;
    if (O_SOFT_RESET) srst_cnt <= srst_cnt + 16'h0001;
  end
  initial begin
    #300000;
    fails++;
    tally_and_finish();
  end
  initial begin
    fails = 0;
    tests_run = 0;
    an_cnt = 16'h0000;
    srst_cnt = 16'h0000;
    an_exp = 16'h0000;
    I_CLOCK = 1'b0;
    I_RST_N = 1'b0;
    I_PHY_ADDR = 5'h03;
    v = 16'($urandom(32'h5349));
    {I_SPEED_STRAP, I_AUTONEG_DEFAULT_STRAP, I_ISOLATE_STRAP, I_DUPLEX_STRAP, I_AN_SPEED_100, I_AN_FULL_DUPLEX} = 6'($urandom);
    strap_w = {2'b00, I_SPEED_STRAP, I_AUTONEG_DEFAULT_STRAP, 1'b0, I_ISOLATE_STRAP, 1'b0, I_DUPLEX_STRAP, 8'h00};
    repeat (16) @(negedge I_CLOCK);
    I_RST_N = 1'b1;
    repeat (3) @(negedge I_CLOCK);
    outs(strap_w);
    rd(5'h00, strap_w);
    rd(5'h01, 16'h7849);
    rd(5'h05, 16'h0000);
    // frame for another address: line stays pulled up
    exq.push_back(16'hFFFF);
    mgr_u.frame(2'h2, 5'h04, 5'h01, 16'h0000);
    for (int k = 0; k < 8; k++) begin
      v = 16'($urandom) & 16'h7FFF;
      v[12] = k[0];
      {I_AN_SPEED_100, I_AN_FULL_DUPLEX} = 2'($urandom);
      mgr_u.frame(2'h1, I_PHY_ADDR, 5'h00, v);
      an_exp = an_exp + {15'h0000, v[9]};
      repeat (2) @(negedge I_CLOCK);
      outs(v);
      rd(5'h00, v & 16'h7D81);
    end
    mgr_u.frame(2'h1, I_PHY_ADDR, 5'h01, 16'hFFFF);
    rd(5'h01, 16'h7849);
    mgr_u.frame(2'h1, I_PHY_ADDR, 5'h00, 16'hC000);
    repeat (3) @(negedge I_CLOCK);
    outs(strap_w);
    rd(5'h00, strap_w);
    check(an_cnt, an_exp);
    check(srst_cnt, 16'h0001);
    I_RST_N = 1'b0;
    repeat (2) @(negedge I_CLOCK);
    {I_SPEED_STRAP, I_AUTONEG_DEFAULT_STRAP, I_ISOLATE_STRAP, I_DUPLEX_STRAP} = 4'($urandom);
    strap_w = {2'b00, I_SPEED_STRAP, I_AUTONEG_DEFAULT_STRAP, 1'b0, I_ISOLATE_STRAP, 1'b0, I_DUPLEX_STRAP, 8'h00};
    I_RST_N = 1'b1;
    repeat (3) @(negedge I_CLOCK);
    outs(strap_w);
    repeat (4) @(negedge I_CLOCK);
    tally_and_finish();
  end
endmodule : pbc_regs_tb
bind pbc_regs pbc_regs_assertions chk_u (.*);
`default_nettype wire
